// ### hdl/eirq_ctrl.sv
`timescale 1ns/1ns
`include "eirq_params.svh"
// Summary of operation
// - Priority register B, 8-bit read/write
// - All registers clear on reset/standby
// - Bit 7 sets timer 3 priority
// - Bit 6 sets timer 4 priority
// - Bit 5 sets shared DMA priority
// - Bit 3 sets serial 0 priority
// - Bit 2 sets serial 1 priority
// - Bit 1 sets converter priority
// - Zero means low, one means high
// - Bits 4 and 0 stored, no effect
// - Flag bits 7 and 6 read zero
// - Flags set on low level or edge
// - Software clears only by writing zero after reading one
// - Level mode clears on acceptance when high
// - Edge mode clears on acceptance
// - Enable bits gate each request
// - Enable bits 7, 6 stored, unused
// - Sense bit picks level or edge
// - Sense bits 7, 6 stored, unused
// - Pins sensed always; vectors 12 to 17

module eirq_ctrl
    import eirq_pkg::*;
(
    // Clock and reset
    input  wire logic        mclk_i,
    input  wire logic        reset_i,
    input  wire logic        hw_standby_i,
    // Avalon-MM slave
    input  wire logic [3:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    output logic [31:0]      avs_readdata_o,
    output logic             avs_waitrequest_o,
    output logic [1:0]       avs_response_o,
    // External request pins, active low
    input  wire logic [5:0]  ext_request_pin_n_i,
    // Exception acceptance from the CPU core
    input  wire logic        exc_accept_i,
    input  wire logic [7:0]  exc_vector_i,
    // Towards the CPU core
    output logic [5:0]       ext_request_o,
    output logic [5:0]       ext_request_vec_ok_o,
    output eirq_prio_s       priority_o
);

    // ******************************************************
    // Pin detection
    // ******************************************************
    logic [5:0] pin_low;
    logic [5:0] pin_fall;
    logic [5:0] pin_high;

    // Pins are sensed whatever their port direction
    genvar gi;
    generate
        for (gi = 0; gi < `EIRQ_NUM_PINS; gi++) begin : g_pin
            eirq_pin_sense u_sense (
                .mclk_i          (mclk_i),
                .reset_i         (reset_i),
                .request_pin_n_i (ext_request_pin_n_i[gi]),
                .level_low_o     (pin_low[gi]),
                .fall_edge_o     (pin_fall[gi]),
                .pin_high_o      (pin_high[gi])
            );
        end
    endgenerate

    // ******************************************************
    // Standby pin synchroniser
    // ******************************************************
    // Standby comes from a pin; two flops guard against metastability.
    // It is a level, so the two-cycle lag only delays the clear.
    logic standby_meta;
    logic standby_sync;
    logic next_standby_meta;
    logic next_standby_sync;

    always_comb begin
        next_standby_meta = hw_standby_i;
        next_standby_sync = standby_meta;
    end

    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            standby_meta <= 1'b0;
            standby_sync <= 1'b0;
        end else begin
            standby_meta <= next_standby_meta;
            standby_sync <= next_standby_sync;
        end
    end

    // ******************************************************
    // Registers
    // ******************************************************
    logic [7:0] ext_request_sense_select;
    logic [7:0] ext_request_enables;
    logic [5:0] pending_flag_n;
    logic [7:0] priority_select_b;
    logic [5:0] read_as_one;
    logic [7:0] next_sense;
    logic [7:0] next_enables;
    logic [5:0] next_flags;
    logic [7:0] next_prio;
    logic [5:0] next_read_as_one;

    // Bus FSM state
    eirq_bus_state_e  state;
    eirq_bus_state_e  next_state;
    eirq_bus_req_s    req;
    logic [31:0]      rdata;
    logic [31:0]      next_rdata;
    logic [1:0]       resp;
    logic [1:0]       next_resp;
    // Waitrequest has its own flop so the port needs no inverter
    logic             wait_req;
    logic             next_wait_req;

    // Vector number for pin n is base plus n
    function automatic logic [5:0] vec_hit(input logic [7:0] vec);
        logic [5:0] hit;
        hit = 6'h00;
        for (int i = 0; i < `EIRQ_NUM_PINS; i++) begin
            hit[i] = (vec == (`EIRQ_VECTOR_BASE + 8'(i)));
        end
        return hit;
    endfunction

    // One-hot register select, shared by the response and the flag paths
    function automatic logic [3:0] reg_sel(input logic [3:0] a);
        logic [3:0] s;
        s    = 4'h0;
        s[0] = (a == `EIRQ_OFS_SENSE);
        s[1] = (a == `EIRQ_OFS_ENABLE);
        s[2] = (a == `EIRQ_OFS_FLAGS);
        s[3] = (a == `EIRQ_OFS_PRIO_B);
        return s;
    endfunction

    always_comb begin
        req.read      = avs_read_i;
        req.write     = avs_write_i;
        req.address   = avs_address_i;
        req.writedata = avs_writedata_i;
    end

    logic       wr_take;
    logic       rd_take;
    logic [3:0] sel;
    logic [5:0] ack_hit;
    logic [5:0] set_cond;
    logic [5:0] clr_cond;

    always_comb begin
        ack_hit = exc_accept_i ? vec_hit(exc_vector_i) : 6'h00;
        wr_take = (state == EIRQ_ANSWER) && req.write;
        rd_take = (state == EIRQ_ANSWER) && req.read;
        sel     = reg_sel(req.address);
    end

    // ******************************************************
    // Per-pin set and acceptance-clear conditions
    // ******************************************************
    logic [5:0] ack_clr;

    generate
        for (gi = 0; gi < `EIRQ_NUM_PINS; gi++) begin : g_cond
            // Edge mode sets on the falling edge, level mode on a low pin
            assign set_cond[gi] = ext_request_sense_select[gi] ?
                                  pin_fall[gi] : pin_low[gi];
            // A level flag may only drop once its pin is back high
            assign ack_clr[gi] = ext_request_sense_select[gi] ?
                                 ack_hit[gi] :
                                 ack_hit[gi] & pin_high[gi];
        end
    endgenerate

    // ******************************************************
    // Register next values
    // ******************************************************
    always_comb begin
        next_sense       = ext_request_sense_select;
        next_enables     = ext_request_enables;
        next_prio        = priority_select_b;
        next_read_as_one = read_as_one;
        clr_cond         = ack_clr;
        if (wr_take) begin
            case (req.address)
                `EIRQ_OFS_SENSE:  next_sense   = req.writedata[7:0];
                `EIRQ_OFS_ENABLE: next_enables = req.writedata[7:0];
                `EIRQ_OFS_PRIO_B: next_prio    = req.writedata[7:0];
                default: ;
            endcase
        end
        // Only a zero written over a flag read as one clears it; ones ignored
        if (wr_take && sel[2]) begin
            clr_cond = clr_cond |
                       (read_as_one & ~req.writedata[5:0]);
            next_read_as_one = read_as_one & req.writedata[5:0];
        end
        // Arm exactly the bits that software was shown as set
        if (rd_take && sel[2]) begin
            next_read_as_one = rdata[5:0];
        end
        // A new event in the clearing cycle wins over the clear
        next_flags = (pending_flag_n & ~clr_cond) | set_cond;
        next_read_as_one = next_read_as_one & next_flags;
    end

    // reset and hardware standby both return registers to zero
    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            ext_request_sense_select <= `EIRQ_RST_SENSE;
            ext_request_enables      <= `EIRQ_RST_ENABLE;
            pending_flag_n           <= `EIRQ_RST_FLAGS;
            priority_select_b        <= `EIRQ_RST_PRIO_B;
            read_as_one              <= 6'h00;
        end else if (standby_sync) begin
            ext_request_sense_select <= `EIRQ_RST_SENSE;
            ext_request_enables      <= `EIRQ_RST_ENABLE;
            pending_flag_n           <= `EIRQ_RST_FLAGS;
            priority_select_b        <= `EIRQ_RST_PRIO_B;
            read_as_one              <= 6'h00;
        end else begin
            ext_request_sense_select <= next_sense;
            ext_request_enables      <= next_enables;
            pending_flag_n           <= next_flags;
            priority_select_b        <= next_prio;
            read_as_one              <= next_read_as_one;
        end
    end

    // ******************************************************
    // Avalon-MM slave
    // ******************************************************
    // Three-state handshake keeps waitrequest registered; one wait cycle
    always_comb begin
        next_state  = state;
        next_rdata  = rdata;
        next_resp   = resp;
        next_wait_req = 1'b1;
        case (state)
            EIRQ_IDLE: begin
                if (req.read || req.write) begin
                    next_state = EIRQ_ANSWER;
                    next_wait_req = 1'b0;
                    next_resp = (|sel) ? 2'h0 : 2'h2;
                    next_rdata = 32'h0000_0000;
                    case (req.address)
                        `EIRQ_OFS_SENSE:
                            next_rdata[7:0] = ext_request_sense_select;
                        `EIRQ_OFS_ENABLE:
                            next_rdata[7:0] = ext_request_enables;
                        `EIRQ_OFS_FLAGS:
                            next_rdata[7:0] = {2'h0, next_flags};
                        `EIRQ_OFS_PRIO_B:
                            next_rdata[7:0] = priority_select_b;
                        default: next_rdata = 32'h0000_0000;
                    endcase
                end
            end
            EIRQ_ANSWER: begin
                next_state = EIRQ_DONE;
            end
            EIRQ_DONE: begin
                // Busy one cycle so the master's release is seen first
                next_state = EIRQ_IDLE;
            end
            default: begin
                next_state = EIRQ_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            state    <= EIRQ_IDLE;
            rdata    <= 32'h0000_0000;
            resp     <= 2'h0;
            wait_req <= 1'b1;
        end else begin
            state    <= next_state;
            rdata    <= next_rdata;
            resp     <= next_resp;
            wait_req <= next_wait_req;
        end
    end

    // ******************************************************
    // Outputs towards the core
    // ******************************************************
    // Registered copies keep every core-facing output glitch free
    logic [5:0]  next_request;
    logic [5:0]  req_q;
    eirq_prio_s  next_priority;
    eirq_prio_s  prio_q;

    always_comb begin
        next_request = pending_flag_n & ext_request_enables[5:0];
        next_priority.timer3    = priority_select_b[`EIRQ_BIT_TIMER3];
        next_priority.timer4    = priority_select_b[`EIRQ_BIT_TIMER4];
        next_priority.dma       = priority_select_b[`EIRQ_BIT_DMA];
        next_priority.serial0   = priority_select_b[`EIRQ_BIT_SERIAL0];
        next_priority.serial1   = priority_select_b[`EIRQ_BIT_SERIAL1];
        next_priority.converter =
            priority_select_b[`EIRQ_BIT_CONVERTER];
    end

    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            req_q  <= 6'h00;
            prio_q <= '0;
        end else begin
            req_q  <= next_request;
            prio_q <= next_priority;
        end
    end

    assign ext_request_o        = req_q;
    assign ext_request_vec_ok_o = req_q;
    assign priority_o           = prio_q;
    assign avs_readdata_o       = rdata;
    assign avs_response_o       = resp;
    assign avs_waitrequest_o    = wait_req;

endmodule // eirq_ctrl

// ### pkg/eirq_params.svh
`ifndef EIRQ_PARAMS_SVH
`define EIRQ_PARAMS_SVH

// Register byte offsets (word aligned, Avalon address = byte offset, no shift)
`define EIRQ_OFS_SENSE      4'h0
`define EIRQ_OFS_ENABLE     4'h4
`define EIRQ_OFS_FLAGS      4'h8
`define EIRQ_OFS_PRIO_B     4'hc

// Reset values
`define EIRQ_RST_SENSE      8'h00
`define EIRQ_RST_ENABLE     8'h00
`define EIRQ_RST_FLAGS      6'h00
`define EIRQ_RST_PRIO_B     8'h00

// Field positions in the priority register
`define EIRQ_BIT_TIMER3     7
`define EIRQ_BIT_TIMER4     6
`define EIRQ_BIT_DMA        5
`define EIRQ_BIT_SERIAL0    3
`define EIRQ_BIT_SERIAL1    2
`define EIRQ_BIT_CONVERTER  1

// Request pins and vector numbers
`define EIRQ_NUM_PINS       6
`define EIRQ_VECTOR_BASE    8'h0c

// Read answer latency in cycles after the request is seen
`define EIRQ_WAIT_CYCLES    1

`endif

// ### pkg/eirq_pkg.sv
package eirq_pkg;

    // Avalon-MM slave request bundle
    typedef struct packed {
        logic        read;
        logic        write;
        logic [3:0]  address;
        logic [31:0] writedata;
    } eirq_bus_req_s;

    // Priority levels handed to the interrupt arbiter
    typedef struct packed {
        logic timer3;
        logic timer4;
        logic dma;
        logic serial0;
        logic serial1;
        logic converter;
    } eirq_prio_s;

    // Exception acceptance reported by the CPU core
    typedef struct packed {
        logic       valid;
        logic [7:0] vector;
    } eirq_ack_s;

    typedef enum logic [2:0] {
        EIRQ_IDLE   = 3'b001,
        EIRQ_ANSWER = 3'b010,
        EIRQ_DONE   = 3'b100
    } eirq_bus_state_e;

endpackage

// ### hdl/eirq_pin_sense.sv
`timescale 1ns/1ns
`include "eirq_params.svh"

module eirq_pin_sense
    import eirq_pkg::*;
(
    // Clock and reset
    input  wire logic       mclk_i,
    input  wire logic       reset_i,
    // Raw active-low pin
    input  wire logic       request_pin_n_i,
    // Detection results
    output logic            level_low_o,
    output logic            fall_edge_o,
    output logic            pin_high_o
);

    logic meta_n;
    logic sync_n;
    logic prev_n;
    logic next_meta_n;
    logic next_sync_n;
    logic next_prev_n;

    always_comb begin
        next_meta_n = request_pin_n_i;
        next_sync_n = meta_n;
        next_prev_n = sync_n;
    end

    // Idle pin level is high, so the chain resets high
    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            meta_n <= 1'b1;
            sync_n <= 1'b1;
            prev_n <= 1'b1;
        end else begin
            meta_n <= next_meta_n;
            sync_n <= next_sync_n;
            prev_n <= next_prev_n;
        end
    end

    assign level_low_o = ~sync_n;
    assign fall_edge_o = prev_n & ~sync_n;
    assign pin_high_o  = sync_n;

endmodule // eirq_pin_sense

// ### tb/eirq_ctrl_chk.sv
`timescale 1ns/1ns
module eirq_ctrl_chk
    import eirq_pkg::*;
(
    // Clock and reset
    input  wire logic        mclk_i,
    input  wire logic        reset_i,
    input  wire logic        hw_standby_i,
    // Register bus
    input  wire logic [3:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    input  wire logic [31:0] avs_readdata_o,
    input  wire logic        avs_waitrequest_o,
    input  wire logic [1:0]  avs_response_o,
    // Requests and priority
    input  wire logic [5:0]  ext_request_pin_n_i,
    input  wire logic        exc_accept_i,
    input  wire logic [7:0]  exc_vector_i,
    input  wire logic [5:0]  ext_request_o,
    input  wire logic [5:0]  ext_request_vec_ok_o,
    input  wire eirq_prio_s  priority_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (reset_i);

    sequence s_req;
        (avs_read_i || avs_write_i) && avs_waitrequest_o;
    endsequence
    sequence s_done;
        (avs_read_i || avs_write_i) && !avs_waitrequest_o;
    endsequence
    sequence s_rd(logic [3:0] a);
        avs_read_i && !avs_waitrequest_o && avs_address_i == a;
    endsequence

    // A pending request may sit out the one busy cycle after a transfer
    property p_answer;
        s_req |-> ##[1:3] !avs_waitrequest_o;
    endproperty
    a_answer: assert property (p_answer)
        else $error("bus request not answered in time");
    property p_wait_one;
        $fell(avs_waitrequest_o) |=> avs_waitrequest_o;
    endproperty
    a_wait_one: assert property (p_wait_one)
        else $error("waitrequest low for more than one cycle");
    property p_prio;
        s_rd(4'hc) |->
            priority_o == {avs_readdata_o[7:5], avs_readdata_o[3:1]};
    endproperty
    a_prio: assert property (p_prio)
        else $error("priority outputs differ from priority register");
    property p_flag_top;
        s_rd(4'h8) |-> avs_readdata_o[31:6] == 26'h0;
    endproperty
    a_flag_top: assert property (p_flag_top)
        else $error("flag register upper bits not zero");
    property p_unmapped;
        s_done ##0 (avs_address_i[1:0] != 2'h0) |-> avs_response_o == 2'h2;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped access not refused");
    property p_mapped;
        s_done ##0 (avs_address_i[1:0] == 2'h0) |-> avs_response_o == 2'h0;
    endproperty
    a_mapped: assert property (p_mapped)
        else $error("mapped access refused");
    property p_vec_ok;
        ext_request_vec_ok_o == ext_request_o;
    endproperty
    a_vec_ok: assert property (p_vec_ok)
        else $error("vector valid outputs differ from requests");
    // Two synchroniser cycles pass before the clear reaches the outputs
    property p_standby;
        hw_standby_i [*3] |-> ##2
            (ext_request_o == 6'h00 && priority_o == 6'h00);
    endproperty
    a_standby: assert property (p_standby)
        else $error("standby did not clear outputs");
endmodule // eirq_ctrl_chk

bind eirq_ctrl eirq_ctrl_chk u_chk (
    .mclk_i(mclk_i), .reset_i(reset_i), .hw_standby_i(hw_standby_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .avs_response_o(avs_response_o),
    .ext_request_pin_n_i(ext_request_pin_n_i), .exc_accept_i(exc_accept_i),
    .exc_vector_i(exc_vector_i), .ext_request_o(ext_request_o),
    .ext_request_vec_ok_o(ext_request_vec_ok_o), .priority_o(priority_o)
);

// ### tb/eirq_cpu_model.sv
`timescale 1ns/1ns
module eirq_cpu_model (
    // Clock and reset
    input  wire logic       mclk_i,
    input  wire logic       reset_i,
    // Requests and bench command
    input  wire logic [5:0] ext_request_i,
    input  wire logic       take_i,
    // Exception acceptance
    output logic            exc_accept_o,
    output logic [7:0]      exc_vector_o
);
    int idx;
    // Lowest request wins; vector is garbage outside the accept pulse
    always @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            exc_accept_o <= 1'b0;
            exc_vector_o <= 8'h00;
        end else if (take_i && |ext_request_i && !exc_accept_o) begin
            for (idx = 5; idx >= 0; idx--) begin
                if (ext_request_i[idx]) break;
            end
            for (int i = 5; i >= 0; i--) begin
                if (ext_request_i[i]) idx = i;
            end
            exc_accept_o <= 1'b1;
            exc_vector_o <= 8'h0c + idx[7:0];
        end else begin
            exc_accept_o <= 1'b0;
            exc_vector_o <= ~exc_vector_o;
        end
    end
endmodule // eirq_cpu_model

// ### tb/eirq_ctrl_tb_top.sv
`timescale 1ns/1ns
module eirq_ctrl_tb_top import eirq_pkg::*;;
    logic        mclk_i = 1'b0;
    logic        reset_i = 1'b1;
    logic        hw_standby_i = 1'b0;
    logic        rd = 1'b0;
    logic        wr = 1'b0;
    logic        take = 1'b0;
    logic [3:0]  addr = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic [5:0]  pins_n = 6'h3f;
    logic [31:0] rdata;
    logic        waitreq;
    logic [1:0]  resp;
    logic        acc;
    logic [7:0]  vec;
    logic [5:0]  req;
    eirq_prio_s  prio;
    logic [31:0] q;
    logic [1:0]  r;
    logic [7:0]  pv [2] = '{8'hae, 8'h51};
    int          mismatches = 0;
    int          comparisons = 0;

    initial forever #2 mclk_i = ~mclk_i;

    eirq_ctrl DUT (
        .mclk_i(mclk_i), .reset_i(reset_i), .hw_standby_i(hw_standby_i),
        .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr),
        .avs_writedata_i(wdata), .avs_readdata_o(rdata),
        .avs_waitrequest_o(waitreq), .avs_response_o(resp),
        .ext_request_pin_n_i(pins_n), .exc_accept_i(acc),
        .exc_vector_i(vec), .ext_request_o(req),
        .ext_request_vec_ok_o(), .priority_o(prio)
    );
    eirq_cpu_model u_cpu (
        .mclk_i(mclk_i), .reset_i(reset_i), .ext_request_i(req),
        .take_i(take), .exc_accept_o(acc), .exc_vector_o(vec)
    );

    // ******************
    // Bus and check tasks
    // ******************
    task final_report;
        $display("mismatches %0d comparisons %0d", mismatches, comparisons);
        if (mismatches == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            mismatches++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask

    task bus(input logic w, input logic [3:0] a, input logic [7:0] d);
        int n;
        @(posedge mclk_i);
        addr <= a;
        rd <= !w;
        wr <= w;
        wdata <= {24'h0, d};
        for (n = 0; n < 20; n++) begin
            @(posedge mclk_i);
            if (waitreq === 1'b0) break;
        end
        if (n == 20) begin
            mismatches++;
            final_report();
        end
        q = rdata;
        r = resp;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask

    task rdc(input logic [3:0] a, input logic [7:0] e);
        bus(1'b0, a, 8'h00);
        chk("readdata", {24'h0, e}, q);
    endtask

    task accept;
        take <= 1'b1;
        @(posedge mclk_i);
        take <= 1'b0;
        repeat (4) @(posedge mclk_i);
    endtask

    // ******************
    // Main sequence
    // ******************
    initial begin
        repeat (16) @(posedge mclk_i);
        reset_i <= 1'b0;
        for (int i = 0; i < 4; i++) rdc(4'(i * 4), 8'h00);
        bus(1'b0, 4'h2, 8'h00);
        chk("response", 32'h2, {30'h0, r});
        foreach (pv[i]) begin
            bus(1'b1, 4'hc, pv[i]);
            rdc(4'hc, pv[i]);
            chk("priority", {26'h0, pv[i][7:5], pv[i][3:1]},
                {26'h0, prio});
        end
        bus(1'b1, 4'h0, 8'hc0);
        rdc(4'h0, 8'hc0);
        bus(1'b1, 4'h4, 8'hff);
        rdc(4'h4, 8'hff);
        // Level sensing: flag outlives the low pin until acceptance
        pins_n <= 6'h3e;
        repeat (6) @(posedge mclk_i);
        chk("request", 32'h01, {26'h0, req});
        rdc(4'h8, 8'h01);
        bus(1'b1, 4'h8, 8'hff);
        pins_n <= 6'h3f;
        repeat (6) @(posedge mclk_i);
        rdc(4'h8, 8'h01);
        accept();
        rdc(4'h8, 8'h00);
        // Edge sensing with pins left low
        bus(1'b1, 4'h0, 8'h3f);
        pins_n <= 6'h1f;
        repeat (6) @(posedge mclk_i);
        rdc(4'h8, 8'h20);
        pins_n <= 6'h0f;
        repeat (6) @(posedge mclk_i);
        bus(1'b1, 4'h8, 8'h00);
        rdc(4'h8, 8'h10);
        bus(1'b1, 4'h4, 8'h00);
        repeat (3) @(posedge mclk_i);
        chk("request", 32'h00, {26'h0, req});
        bus(1'b1, 4'h4, 8'h10);
        repeat (3) @(posedge mclk_i);
        chk("request", 32'h10, {26'h0, req});
        accept();
        rdc(4'h8, 8'h00);
        // Standby clears everything, a set flag included
        bus(1'b1, 4'hc, 8'hff);
        pins_n <= 6'h0e;
        repeat (6) @(posedge mclk_i);
        rdc(4'h8, 8'h01);
        // Pins released so the cleared level mode cannot set flags again
        hw_standby_i <= 1'b1;
        pins_n <= 6'h3f;
        repeat (3) @(posedge mclk_i);
        hw_standby_i <= 1'b0;
        for (int i = 0; i < 4; i++) rdc(4'(i * 4), 8'h00);
        chk("priority", 32'h0, {26'h0, prio});
        final_report();
    end
endmodule // eirq_ctrl_tb_top
